// File: src/uief_top.sv
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uief_cfg.svh"

module uief_top #(
  parameter int unsigned IDLE_CYC = (`UIEF_IDLE_US * `UIEF_CLK_MHZ)
) (
  // Clock and reset
  input  wire logic                    SYS_CLK,
  input  wire logic                    RST_N,
  // Register port
  input  wire logic [`UIEF_ADDR_W-1:0] ADDR,
  input  wire logic [31:0]             WDATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  output logic      [31:0]             RDATA,
  // Role and bus line state
  input  wire logic                    HOST_ROLE_ENABLE,
  input  wire logic                    LINE_SE0,
  input  wire logic                    LINE_K,
  input  wire logic                    LINE_IDLE,
  // Protocol engine event strobes
  input  wire logic                    STALL_SEEN,
  input  wire logic                    ATTACH_SEEN,
  input  wire logic                    TOKEN_DONE,
  input  wire logic [7:0]              TOKEN_STAT,
  input  wire logic                    SOF_SEEN,
  input  wire logic                    RESET_DETACH_SEEN,
  input  wire logic                    STUFF_ERR,
  input  wire logic                    BMX_ERR,
  input  wire logic                    DMA_ERR,
  input  wire logic                    TURN_ERR,
  input  wire logic                    FSIZE_ERR,
  input  wire logic                    CRC16_ERR,
  input  wire logic                    CRC5_EOF_ERR,
  input  wire logic                    PID_ERR,
  // Interrupt and status FIFO full
  output logic                         MODULE_INTERRUPT_REQUEST,
  output logic                         STAT_FIFO_FULL
);

  // --------------------------------------------------------------------------
  // Timing and FIFO size constants
  // --------------------------------------------------------------------------
  localparam int unsigned LINE_CYC = (`UIEF_LINE_NS * `UIEF_CLK_MHZ + 999) / 1000;
  localparam int unsigned DEPTH    = `UIEF_FIFO_DEPTH;

  // --------------------------------------------------------------------------
  // Input synchronisers for the bus line levels and the host role enable
  // --------------------------------------------------------------------------
  // Two stages keep the line levels from reaching logic while metastable.
  logic [2:0] line_m_r;
  logic [2:0] line_s_r;
  logic       host_m_r;
  logic       host_s_r;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      line_m_r <= 3'h0;
      line_s_r <= 3'h0;
      host_m_r <= 1'b0;
      host_s_r <= 1'b0;
    end else begin
      line_m_r <= {LINE_SE0, LINE_K, LINE_IDLE};
      line_s_r <= line_m_r;
      host_m_r <= HOST_ROLE_ENABLE;
      host_s_r <= host_m_r;
    end
  end

  wire logic se0_s  = line_s_r[2];
  wire logic k_s    = line_s_r[1];
  wire logic idle_s = line_s_r[0];

  // --------------------------------------------------------------------------
  // Line timers
  // --------------------------------------------------------------------------
  // Each timer restarts from zero as soon as its line condition drops.
  function automatic uief_pkg::uief_cnt_t bump(input uief_pkg::uief_cnt_t c,
                                               input logic run,
                                               input int unsigned lim);
    if (!run) begin
      bump = '0;
    end else if (32'(c) < lim) begin
      bump = c + 17'h0_0001;
    end else begin
      bump = c;
    end
  endfunction : bump

  uief_pkg::uief_cnt_t k_cnt_r;
  uief_pkg::uief_cnt_t quiet_cnt_r;
  uief_pkg::uief_cnt_t idle_cnt_r;
  logic                k_hit_r;
  logic                idle_hit_r;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      k_cnt_r     <= '0;
      quiet_cnt_r <= '0;
      idle_cnt_r  <= '0;
      k_hit_r     <= 1'b0;
      idle_hit_r  <= 1'b0;
    end else begin
      k_cnt_r     <= bump(k_cnt_r, k_s, LINE_CYC);
      quiet_cnt_r <= bump(quiet_cnt_r, idle_s, LINE_CYC);
      idle_cnt_r  <= bump(idle_cnt_r, idle_s, IDLE_CYC);
      k_hit_r     <= k_s && (32'(k_cnt_r) == LINE_CYC - 1);
      idle_hit_r  <= idle_s && (32'(idle_cnt_r) == IDLE_CYC - 1);
    end
  end

  wire logic quiet_ok = (32'(quiet_cnt_r) >= LINE_CYC);

  // --------------------------------------------------------------------------
  // Register access decode
  // --------------------------------------------------------------------------
  function automatic logic reg_hit(input logic                    strobe,
                                   input logic [`UIEF_ADDR_W-1:0] at,
                                   input logic [`UIEF_ADDR_W-1:0] ofs);
    reg_hit = strobe && (at == ofs);
  endfunction : reg_hit

  // A set in the same cycle as a write-one clear wins.
  function automatic uief_pkg::uief_byte_t w1c(input uief_pkg::uief_byte_t cur,
                                               input logic                 hit,
                                               input uief_pkg::uief_byte_t ones,
                                               input uief_pkg::uief_byte_t set);
    w1c = (cur & ~(hit ? ones : `UIEF_BYTE_ZERO)) | set;
  endfunction : w1c

  wire logic wr_evt  = reg_hit(WR, ADDR, `UIEF_OFS_EVT_FLAGS);
  wire logic wr_eien = reg_hit(WR, ADDR, `UIEF_OFS_EVT_EN);
  wire logic wr_err  = reg_hit(WR, ADDR, `UIEF_OFS_ERR_FLAGS);
  wire logic wr_eren = reg_hit(WR, ADDR, `UIEF_OFS_ERR_EN);
  wire uief_pkg::uief_byte_t wlo = WDATA[7:0];

  // --------------------------------------------------------------------------
  // Enable registers
  // --------------------------------------------------------------------------
  uief_pkg::uief_byte_t evt_en_r;
  uief_pkg::uief_byte_t err_en_r;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      evt_en_r <= `UIEF_BYTE_ZERO;
      err_en_r <= `UIEF_BYTE_ZERO;
    end else begin
      if (wr_eien) begin
        evt_en_r <= wlo;
      end
      if (wr_eren) begin
        err_en_r <= wlo;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Error flags
  // --------------------------------------------------------------------------
  uief_pkg::uief_byte_t err_r;
  uief_pkg::uief_byte_t err_set;

  always_comb begin
    err_set = `UIEF_BYTE_ZERO;
    err_set[`UIEF_ERR_STUFF]    = STUFF_ERR;
    err_set[`UIEF_ERR_BMX]      = BMX_ERR;
    err_set[`UIEF_ERR_DMA]      = DMA_ERR;
    err_set[`UIEF_ERR_TURN]     = TURN_ERR;
    err_set[`UIEF_ERR_FSIZE]    = FSIZE_ERR;
    err_set[`UIEF_ERR_CRC16]    = CRC16_ERR;
    err_set[`UIEF_ERR_CRC5_EOF] = CRC5_EOF_ERR;
    err_set[`UIEF_ERR_PID]      = PID_ERR;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      err_r <= `UIEF_BYTE_ZERO;
    end else begin
      err_r <= w1c(err_r, wr_err, wlo, err_set);
    end
  end

  // --------------------------------------------------------------------------
  // Transfer status FIFO
  // --------------------------------------------------------------------------
  uief_pkg::uief_byte_t stat_mem_r [DEPTH];
  logic [1:0]           wp_r;
  logic [1:0]           rp_r;
  logic [2:0]           cnt_r;

  uief_pkg::uief_byte_t evt_r;
  wire logic tok_clr = wr_evt && wlo[`UIEF_EVT_TOKEN] && evt_r[`UIEF_EVT_TOKEN];
  wire logic pop     = tok_clr && (cnt_r != 3'h0);
  // A completion that arrives while all entries are held is dropped unless an entry is popped in the same cycle.
  wire logic push    = TOKEN_DONE && (cnt_r != 3'(DEPTH) || pop);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wp_r  <= 2'h0;
      rp_r  <= 2'h0;
      cnt_r <= 3'h0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 2'h1;
      end
      if (pop) begin
        rp_r <= rp_r + 2'h1;
      end
      cnt_r <= cnt_r + {2'h0, push} - {2'h0, pop};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (push) begin
      stat_mem_r[wp_r] <= TOKEN_STAT & `UIEF_STAT_KEEP;
    end
  end

  // Flag stays set while entries remain after an advance.
  wire logic tok_more = (cnt_r > 3'h1) || (cnt_r == 3'h1 && push);

  // --------------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------------
  uief_pkg::uief_byte_t evt_set;
  wire logic            errsum_nxt = |(err_r & err_en_r);

  always_comb begin
    evt_set = `UIEF_BYTE_ZERO;
    evt_set[`UIEF_EVT_STALL]  = STALL_SEEN;
    evt_set[`UIEF_EVT_ATTACH] = ATTACH_SEEN && host_s_r && quiet_ok && !se0_s;
    evt_set[`UIEF_EVT_RESUME] = k_hit_r;
    evt_set[`UIEF_EVT_IDLE]   = idle_hit_r;
    evt_set[`UIEF_EVT_TOKEN]  = TOKEN_DONE || (tok_clr && tok_more);
    evt_set[`UIEF_EVT_SOF]    = SOF_SEEN;
    evt_set[`UIEF_EVT_RESET]  = RESET_DETACH_SEEN;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      evt_r <= `UIEF_BYTE_ZERO;
    end else begin
      evt_r <= w1c(evt_r, wr_evt, wlo, evt_set);
    end
  end

  // --------------------------------------------------------------------------
  // Error summary
  // --------------------------------------------------------------------------
  // The summary mirrors the enabled errors, so a write to the event flags cannot clear it.
  logic                 errsum_r;
  uief_pkg::uief_byte_t evt_view;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      errsum_r <= 1'b0;
    end else begin
      errsum_r <= errsum_nxt;
    end
  end

  always_comb begin
    evt_view                   = evt_r;
    evt_view[`UIEF_EVT_ERRSUM] = errsum_r;
  end

  // --------------------------------------------------------------------------
  // Interrupt request and FIFO full flag
  // --------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      MODULE_INTERRUPT_REQUEST <= 1'b0;
    end else begin
      MODULE_INTERRUPT_REQUEST <= |(evt_view & evt_en_r);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      STAT_FIFO_FULL <= 1'b0;
    end else begin
      STAT_FIFO_FULL <= (cnt_r == 3'(DEPTH));
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Status reads as zero while no completed token is pending.
  uief_pkg::uief_byte_t stat_view;

  always_comb begin
    stat_view = `UIEF_BYTE_ZERO;
    if (evt_r[`UIEF_EVT_TOKEN] && cnt_r != 3'h0) begin
      stat_view = stat_mem_r[rp_r];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RDATA <= `UIEF_WORD_ZERO;
    end else if (RD) begin
      unique case (ADDR)
        `UIEF_OFS_EVT_FLAGS: RDATA <= {24'h00_0000, evt_view};
        `UIEF_OFS_EVT_EN:    RDATA <= {24'h00_0000, evt_en_r};
        `UIEF_OFS_ERR_FLAGS: RDATA <= {24'h00_0000, err_r};
        `UIEF_OFS_ERR_EN:    RDATA <= {24'h00_0000, err_en_r};
        `UIEF_OFS_XFER_STAT: RDATA <= {24'h00_0000, stat_view};
        default:             RDATA <= `UIEF_WORD_ZERO;
      endcase
    end else begin
      RDATA <= `UIEF_WORD_ZERO;
    end
  end

endmodule : uief_top
`default_nettype wire

// File: src/uief_cfg.svh
`ifndef UIEF_CFG_SVH
`define UIEF_CFG_SVH

// ----------------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------------
`define UIEF_ADDR_W           4
`define UIEF_OFS_EVT_FLAGS    4'h0
`define UIEF_OFS_EVT_EN       4'h1
`define UIEF_OFS_ERR_FLAGS    4'h2
`define UIEF_OFS_ERR_EN       4'h3
`define UIEF_OFS_XFER_STAT    4'h4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UIEF_EVT_STALL        7
`define UIEF_EVT_ATTACH       6
`define UIEF_EVT_RESUME       5
`define UIEF_EVT_IDLE         4
`define UIEF_EVT_TOKEN        3
`define UIEF_EVT_SOF          2
`define UIEF_EVT_ERRSUM       1
`define UIEF_EVT_RESET        0
`define UIEF_ERR_STUFF        7
`define UIEF_ERR_BMX          6
`define UIEF_ERR_DMA          5
`define UIEF_ERR_TURN         4
`define UIEF_ERR_FSIZE        3
`define UIEF_ERR_CRC16        2
`define UIEF_ERR_CRC5_EOF     1
`define UIEF_ERR_PID          0
`define UIEF_STAT_KEEP        8'hFC

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define UIEF_BYTE_ZERO        8'h00
`define UIEF_WORD_ZERO        32'h0000_0000
`define UIEF_CLK_MHZ          25
`define UIEF_LINE_NS          2500
`define UIEF_IDLE_US          3000
`define UIEF_CNT_W            17
`define UIEF_FIFO_DEPTH       4

`endif

// File: src/uief_pkg.sv
package uief_pkg;
  typedef logic [7:0] uief_byte_t;
  typedef logic [16:0] uief_cnt_t;
  typedef enum logic {UIEF_FUNC, UIEF_HOST} uief_role_e;
endpackage : uief_pkg

// File: bench/uief_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module uief_engine_model (
  // Clock and requests from the bench
  input  wire logic        clk,
  input  wire logic [15:0] req,
  input  wire logic [7:0]  stat_in,
  input  wire logic [2:0]  line_req,
  // Strobes, status byte and line levels toward the block
  output logic      [15:0] pulse = 16'h0000,
  output logic      [7:0]  stat = 8'h00,
  output logic      [2:0]  line = 3'b000
);
  // Every strobe follows its request one cycle later and lasts as long as it; the status byte is only meaningful with its strobe.
  always_ff @(posedge clk) begin
    pulse <= req;
    stat  <= req[11] ? stat_in : ~stat;
    line  <= line_req;
  end
endmodule : uief_engine_model
`default_nettype wire

// File: bench/uief_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module uief_top_assertions (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic [3:0]  ADDR,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        STALL_SEEN,
  input wire logic        TOKEN_DONE,
  input wire logic        SOF_SEEN,
  input wire logic        RESET_DETACH_SEEN,
  input wire logic        STUFF_ERR,
  input wire logic        PID_ERR,
  input wire logic        MODULE_INTERRUPT_REQUEST,
  input wire logic        STAT_FIFO_FULL
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  chk_upper_zero: assert property (RD |=> RDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_stall_seen: assert property (STALL_SEEN ##1 !WR ##1 (RD && ADDR == 4'h0) |=> RDATA[7])
    else $error("stall flag not set");
  chk_token_seen: assert property (TOKEN_DONE ##1 !WR ##1 (RD && ADDR == 4'h0) |=> RDATA[3])
    else $error("token flag not set");
  chk_sof_seen: assert property (SOF_SEEN ##1 !WR ##1 (RD && ADDR == 4'h0) |=> RDATA[2])
    else $error("frame start flag not set");
  chk_bus_reset: assert property (RESET_DETACH_SEEN ##1 !WR ##1 (RD && ADDR == 4'h0) |=> RDATA[0])
    else $error("bus reset flag not set");
  chk_stuff_err: assert property (STUFF_ERR ##1 !WR ##1 (RD && ADDR == 4'h2) |=> RDATA[7])
    else $error("bit stuff flag not set");
  chk_pid_err: assert property (PID_ERR ##1 !WR ##1 (RD && ADDR == 4'h2) |=> RDATA[0])
    else $error("packet id flag not set");
  chk_irq_reset: assert property ($rose(RST_N) |-> !MODULE_INTERRUPT_REQUEST)
    else $error("interrupt high after reset");
  cover property (MODULE_INTERRUPT_REQUEST);
  cover property (STAT_FIFO_FULL);
  cover property (TOKEN_DONE ##2 RD);
endmodule : uief_top_assertions
bind uief_top uief_top_assertions u_uief_top_assertions (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
  .STALL_SEEN(STALL_SEEN), .TOKEN_DONE(TOKEN_DONE), .SOF_SEEN(SOF_SEEN),
  .RESET_DETACH_SEEN(RESET_DETACH_SEEN), .STUFF_ERR(STUFF_ERR), .PID_ERR(PID_ERR),
  .MODULE_INTERRUPT_REQUEST(MODULE_INTERRUPT_REQUEST), .STAT_FIFO_FULL(STAT_FIFO_FULL));
`default_nettype wire

// File: bench/uief_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module uief_top_tb_top;
  localparam int unsigned IDLE_N = 200;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        host = 1'b0;
  logic [15:0] req = 16'h0;
  logic [7:0]  stat_in = 8'h00;
  logic [2:0]  line_req = 3'b000;
  logic [15:0] pulse;
  logic [7:0]  stat;
  logic [2:0]  line;
  logic [31:0] rdata;
  logic        irq;
  logic        full;
  int          fails = 0;
  int          n_tests = 0;
  always #20 clk = ~clk;
  uief_engine_model u_uief_engine_model (.clk(clk), .req(req), .stat_in(stat_in),
    .line_req(line_req), .pulse(pulse), .stat(stat), .line(line));
  uief_top #(.IDLE_CYC(IDLE_N)) u_uief_top (.SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .HOST_ROLE_ENABLE(host),
    .LINE_SE0(line[0]), .LINE_K(line[2]), .LINE_IDLE(line[1]), .STALL_SEEN(pulse[15]),
    .ATTACH_SEEN(pulse[14]), .TOKEN_DONE(pulse[11]), .TOKEN_STAT(stat),
    .SOF_SEEN(pulse[10]), .RESET_DETACH_SEEN(pulse[8]), .STUFF_ERR(pulse[7]),
    .BMX_ERR(pulse[6]), .DMA_ERR(pulse[5]), .TURN_ERR(pulse[4]), .FSIZE_ERR(pulse[3]),
    .CRC16_ERR(pulse[2]), .CRC5_EOF_ERR(pulse[1]), .PID_ERR(pulse[0]),
    .MODULE_INTERRUPT_REQUEST(irq), .STAT_FIFO_FULL(full));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr32(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr32
  task automatic rdm(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    cmp(rdata & m, exp);
  endtask : rdm
  task automatic fire(input int idx);
    @(posedge clk);
    req[idx] <= 1'b1;
    @(posedge clk);
    req <= 16'h0;
    @(posedge clk);
  endtask : fire
  task automatic irq_is(input logic exp);
    @(posedge clk);
    #1;
    cmp({31'h0, irq}, {31'h0, exp});
  endtask : irq_is
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (logic [3:0] a = 4'h0; a < 4'h6; a++) rdm(a, 32'h0, ALL);
    wr32(4'h5, 32'hFF);
    rdm(4'h5, 32'h0, ALL);
    wr32(4'h1, ALL);
    rdm(4'h1, 32'hFF, ALL);
    wr32(4'h3, 32'hA5);
    rdm(4'h3, 32'hA5, ALL);
    wr32(4'h1, 32'h0);
    wr32(4'h3, 32'h0);
    for (int b = 0; b < 8; b++) begin
      if (b == 7 || b == 2 || b == 0) begin
        fire(b + 8);
        rdm(4'h0, 32'h1 << b, ALL);
        wr32(4'h0, 32'h1 << b);
        rdm(4'h0, 32'h0, ALL);
      end
      fire(b);
      rdm(4'h2, 32'h1 << b, ALL);
      rdm(4'h0, 32'h0, 32'h2);
      wr32(4'h2, 32'h0);
      rdm(4'h2, 32'h1 << b, ALL);
      wr32(4'h2, 32'h1 << b);
      rdm(4'h2, 32'h0, ALL);
    end
    wr32(4'h3, 32'h01);
    wr32(4'h1, 32'h02);
    fire(0);
    rdm(4'h0, 32'h2, 32'h2);
    irq_is(1'b1);
    wr32(4'h1, 32'h5D);
    irq_is(1'b0);
    wr32(4'h2, 32'h1);
    rdm(4'h0, 32'h0, 32'h2);
    fire(15);
    irq_is(1'b0);
    wr32(4'h1, 32'h80);
    irq_is(1'b1);
    wr32(4'h0, 32'h80);
    irq_is(1'b0);
    for (int i = 1; i < 6; i++) begin
      stat_in <= {i[3:0], 4'hF};
      fire(11);
    end
    #1;
    cmp({31'h0, full}, 32'h1);
    for (int i = 1; i < 5; i++) begin
      rdm(4'h4, {24'h0, i[3:0], 4'hC}, ALL);
      rdm(4'h0, 32'h8, 32'h8);
      wr32(4'h0, 32'h8);
    end
    rdm(4'h0, 32'h0, 32'h8);
    rdm(4'h4, 32'h0, ALL);
    line_req <= 3'b100;
    repeat (30) @(posedge clk);
    rdm(4'h0, 32'h0, 32'h20);
    repeat (80) @(posedge clk);
    rdm(4'h0, 32'h20, 32'h20);
    line_req <= 3'b010;
    repeat (IDLE_N - 30) @(posedge clk);
    rdm(4'h0, 32'h0, 32'h10);
    fire(14);
    rdm(4'h0, 32'h0, 32'h40);
    @(posedge clk);
    host <= 1'b1;
    repeat (40) @(posedge clk);
    rdm(4'h0, 32'h10, 32'h10);
    fire(14);
    rdm(4'h0, 32'h40, 32'h40);
    wr32(4'h0, 32'h40);
    line_req <= 3'b011;
    repeat (4) @(posedge clk);
    fire(14);
    rdm(4'h0, 32'h0, 32'h40);
    wr32(4'h1, 32'h10);
    irq_is(1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    irq_is(1'b0);
    for (logic [3:0] a = 4'h0; a < 4'h5; a++) rdm(a, 32'h0, ALL);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
endmodule : uief_top_tb_top
`default_nettype wire
